// >>> hw/urx_defs.svh
// register offsets, field positions, reset values and timing counts of the uart receiver
`ifndef URX_DEFS_SVH
`define URX_DEFS_SVH
`define URX_OFF_STATUS 12'h000
`define URX_OFF_DATA 12'h004
`define URX_OFF_CTRL 12'h008
`define URX_OFF_BAUD 12'h00C
// status fields
`define URX_ST_RX_DATA_AVAILABLE_FLAG 0
`define URX_ST_OVERRUN_FLAG 1
`define URX_ST_NF 2
`define URX_ST_FRAMING_ERROR_FLAG 3
`define URX_ST_PARITY_ERROR_FLAG 4
`define URX_ST_RX_IDLE_FLAG 5
`define URX_ST_RX8 6
// control fields
`define URX_CT_RX_ENABLE 0
`define URX_CT_BNO 1
`define URX_CT_PARITY_ENABLE 2
`define URX_CT_PRT 3
`define URX_CT_STOP_BITS_SELECT 4
`define URX_CT_RIE 5
`define URX_CT_ADDRESS_DETECT_ENABLE 6
`define URX_CT_WAKE 7
`define URX_CT_IDLE_ZERO_MODE 8
`define URX_CTRL_RST 9'h000
`define URX_BAUD_RST 16'h0000
// oversampling: 16 ticks per bit, votes at ticks 7,8,9
`define URX_OVS 4'hF
`define URX_MID 4'h8
`define URX_BRK_BITS 5'd13
`endif

// >>> hw/urx_pkg.sv
// types shared by the uart receiver
package urx_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_START,
      ST_DATA,
      ST_STOP
   } urx_state_t;
endpackage

// >>> hw/urx_receiver.sv
// uart receive path with apb register access
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`include "urx_defs.svh"

module urx_receiver (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_pin,
   input wire logic sleep_mode,
   output logic rx_owned,
   output logic wake_req,
   output logic uart_irq_n
);

   // ---------------------------------------------------------------
   // register access decode
   // ---------------------------------------------------------------
   logic [8:0] ctrl_r;
   logic [15:0] baud_divisor_reg_r;
   wire apb_acc = psel && penable;
   wire apb_wr = apb_acc && pwrite;
   wire apb_rd = apb_acc && !pwrite;
   wire hit_st = paddr == `URX_OFF_STATUS;
   wire hit_dat = paddr == `URX_OFF_DATA;
   wire hit_ct = paddr == `URX_OFF_CTRL;
   wire hit_bd = paddr == `URX_OFF_BAUD;
   wire hit_any = hit_st || hit_dat || hit_ct || hit_bd;
   wire rx_enable = ctrl_r[`URX_CT_RX_ENABLE];
   wire nine_bit_select = ctrl_r[`URX_CT_BNO];
   wire parity_enable = ctrl_r[`URX_CT_PARITY_ENABLE];
   wire parity_type_select = ctrl_r[`URX_CT_PRT];
   wire rx_interrupt_enable = ctrl_r[`URX_CT_RIE];
   wire address_detect_enable = ctrl_r[`URX_CT_ADDRESS_DETECT_ENABLE];
   wire wake_enable = ctrl_r[`URX_CT_WAKE];
   wire idle_zero_mode = ctrl_r[`URX_CT_IDLE_ZERO_MODE];
   assign pready = 1'b1; // zero wait states
   assign pslverr = apb_acc && !hit_any;
   assign rx_owned = rx_enable;

   // control registers; stop bit count is held but only the first is checked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `URX_CTRL_RST;
         baud_divisor_reg_r <= `URX_BAUD_RST;
      end else begin
         if (apb_wr && hit_ct) ctrl_r <= pwdata[8:0];
         if (apb_wr && hit_bd) baud_divisor_reg_r <= pwdata[15:0];
      end
   end

   // ---------------------------------------------------------------
   // oversampling tick: sixteen per bit
   // ---------------------------------------------------------------
   logic [15:0] div_cnt_r;
   wire tick = div_cnt_r == 16'h0000;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) div_cnt_r <= 16'h0000;
      else if (tick || !rx_enable) div_cnt_r <= baud_divisor_reg_r;
      else div_cnt_r <= div_cnt_r - 16'h0001;
   end

   // three-sample majority over a shift of the raw line
   logic [2:0] samp_r;
   wire vote = (samp_r[0] & samp_r[1]) | (samp_r[1] & samp_r[2]) | (samp_r[0] & samp_r[2]);
   wire disagree = !(samp_r == 3'b000 || samp_r == 3'b111);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) samp_r <= 3'b111;
      else if (tick) samp_r <= {samp_r[1:0], rx_pin};
   end

   // ---------------------------------------------------------------
   // receive state machine
   // ---------------------------------------------------------------
   urx_pkg::urx_state_t state_r;
   logic [3:0] ovs_r;
   logic [3:0] bit_r;
   logic [8:0] rx_shift_register_r;
   logic noise_r;
   logic wait_high_r;
   logic done_r;
   logic done_framing_error_flag_r;
   logic done_parity_error_flag_r;
   logic done_noise_r;
   logic [8:0] done_word_r;
   wire [3:0] nbits = nine_bit_select ? 4'd9 : 4'd8;
   wire [3:0] frame_bits = nbits;
   wire at_mid = tick && ovs_r == `URX_MID;
   // parity is the word's top bit when enabled; 9-bit word has bits [8:0]
   wire [8:0] word_in = {vote, rx_shift_register_r[8:1]};
   wire [8:0] word_al = nine_bit_select ? rx_shift_register_r : {1'b0, rx_shift_register_r[8:1]};
   wire par_bit = nine_bit_select ? word_al[8] : word_al[7];
   wire par_calc = nine_bit_select ? ^word_al[7:0] : ^word_al[6:0];
   wire par_bad = parity_enable && ((par_calc ^ par_bit) != parity_type_select);

   // the break level never counts as a start until a high is seen or the receiver is disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= urx_pkg::ST_IDLE;
         ovs_r <= 4'h0;
         bit_r <= 4'h0;
         rx_shift_register_r <= 9'h000;
         noise_r <= 1'b0;
         wait_high_r <= 1'b0;
         done_r <= 1'b0;
         done_framing_error_flag_r <= 1'b0;
         done_parity_error_flag_r <= 1'b0;
         done_noise_r <= 1'b0;
         done_word_r <= 9'h000;
      end else begin
         done_r <= 1'b0;
         if (!rx_enable) begin
            state_r <= urx_pkg::ST_IDLE;
            wait_high_r <= 1'b0;
         end else begin
            case (state_r)
               urx_pkg::ST_IDLE: begin
                  if (tick && wait_high_r && vote) wait_high_r <= 1'b0;
                  if (tick && !wait_high_r && !vote) begin
                     state_r <= urx_pkg::ST_START;
                     ovs_r <= 4'h1;
                     noise_r <= 1'b0;
                  end
               end
               urx_pkg::ST_START: begin
                  if (tick) ovs_r <= ovs_r + 4'h1;
                  if (at_mid) begin
                     noise_r <= disagree;
                     if (vote) state_r <= urx_pkg::ST_IDLE; // false start
                     else begin
                        state_r <= urx_pkg::ST_DATA;
                        bit_r <= 4'h0;
                     end
                  end
               end
               urx_pkg::ST_DATA: begin
                  if (tick) ovs_r <= ovs_r + 4'h1;
                  if (at_mid) begin
                     rx_shift_register_r <= word_in;
                     noise_r <= noise_r | disagree;
                     bit_r <= bit_r + 4'h1;
                     if (bit_r + 4'h1 == frame_bits) state_r <= urx_pkg::ST_STOP;
                  end
               end
               urx_pkg::ST_STOP: begin
                  if (tick) ovs_r <= ovs_r + 4'h1;
                  if (at_mid) begin // only first stop bit checked
                     state_r <= urx_pkg::ST_IDLE;
                     done_r <= 1'b1;
                     done_word_r <= word_al;
                     done_framing_error_flag_r <= !vote;
                     done_parity_error_flag_r <= par_bad;
                     done_noise_r <= noise_r | disagree;
                     wait_high_r <= !vote;
                  end
               end
               default: state_r <= urx_pkg::ST_IDLE;
            endcase
         end
      end
   end
   // idle shown outside a frame; a break ends as a frame of zeros with its framing error flag set
   wire rx_idle_flag = state_r == urx_pkg::ST_IDLE;

   // ---------------------------------------------------------------
   // two-entry receive fifo with per-word error flags
   // ---------------------------------------------------------------
   logic [10:0] fifo_r [0:1];
   logic rd_ptr_r;
   logic wr_ptr_r;
   logic [1:0] cnt_r;
   logic status_seen_r;
   logic overrun_flag_r;
   logic noise_flag_r;
   wire data_rd = apb_rd && hit_dat;
   wire pop = data_rd && cnt_r != 2'd0;
   wire fifo_full = cnt_r == 2'd2;
   wire push = done_r && (!fifo_full || pop);
   wire ovr_evt = done_r && fifo_full && !pop;
   wire clr_seq = data_rd && status_seen_r;
   wire rx_data_available_flag = cnt_r != 2'd0;
   wire [10:0] head = fifo_r[rd_ptr_r];

   // word storage indexed by write pointer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_r[0] <= 11'h000;
         fifo_r[1] <= 11'h000;
      end else if (push) begin
         fifo_r[wr_ptr_r] <= {done_parity_error_flag_r, done_framing_error_flag_r, done_word_r};
      end
   end

   // pointers, count and sticky flags; a set in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ptr_r <= 1'b0;
         wr_ptr_r <= 1'b0;
         cnt_r <= 2'd0;
         status_seen_r <= 1'b0;
         overrun_flag_r <= 1'b0;
         noise_flag_r <= 1'b0;
      end else begin
         if (push) wr_ptr_r <= !wr_ptr_r;
         if (pop) rd_ptr_r <= !rd_ptr_r;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
         if (apb_rd && hit_st) status_seen_r <= 1'b1;
         else if (data_rd) status_seen_r <= 1'b0;
         // flags written by software are ignored
         if (ovr_evt) overrun_flag_r <= 1'b1;
         else if (clr_seq) overrun_flag_r <= 1'b0;
         if (push && done_noise_r) noise_flag_r <= 1'b1;
         else if (clr_seq) noise_flag_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // read data and interrupt request
   // ---------------------------------------------------------------
   // error bits of the head word; software reads them before data
   wire [31:0] status_word = {25'h000_0000, head[8] & rx_data_available_flag,
      rx_idle_flag, head[10] & rx_data_available_flag, head[9] & rx_data_available_flag,
      noise_flag_r, overrun_flag_r, rx_data_available_flag};
   wire [31:0] rd_mux = hit_st ? status_word :
      hit_dat ? {24'h00_0000, head[7:0]} :
      hit_ct ? {23'h00_0000, ctrl_r} :
      hit_bd ? {16'h0000, baud_divisor_reg_r} : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite) prdata <= rd_mux;
   end

   // address bit is the top bit of the word; transmit sources live elsewhere
   wire addr_bit = nine_bit_select ? done_word_r[8] : done_word_r[7];
   wire rx_evt = push && (!address_detect_enable || addr_bit);
   logic rx_d_r;
   wire rx_fall = rx_d_r && !rx_pin;
   wire wake_evt = (idle_zero_mode || sleep_mode) && wake_enable && rx_enable && rx_fall;
   wire irq_evt = rx_interrupt_enable && (rx_evt || ovr_evt || wake_evt);

   // one-cycle low pulse per cycle with an enabled event; events in one cycle share it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_d_r <= 1'b1;
         uart_irq_n <= 1'b1;
         wake_req <= 1'b0;
      end else begin
         rx_d_r <= rx_pin;
         uart_irq_n <= !irq_evt;
         wake_req <= wake_evt;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_irq_pulse;
      @(posedge pclk) disable iff (!presetn) !uart_irq_n |=> uart_irq_n || $past(irq_evt);
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq low without event");
   property p_ovr;
      @(posedge pclk) disable iff (!presetn) ovr_evt |=> overrun_flag_r && cnt_r == 2'd2;
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun lost or fifo changed");
   property p_avail;
      @(posedge pclk) disable iff (!presetn) push |=> rx_data_available_flag;
   endproperty
   a_avail: assert property (p_avail) else $error("no data available after push");
   property p_cnt;
      @(posedge pclk) disable iff (!presetn) cnt_r <= 2'd2;
   endproperty
   a_cnt: assert property (p_cnt) else $error("fifo count above two");
   property p_rxirq;
      @(posedge pclk) disable iff (!presetn)
         push && rx_interrupt_enable && !address_detect_enable |=> !uart_irq_n;
   endproperty
   a_rxirq: assert property (p_rxirq) else $error("no irq on word load");
   property p_address_detect_enable;
      @(posedge pclk) disable iff (!presetn)
         push && address_detect_enable && !addr_bit && !ovr_evt && !wake_evt |=> uart_irq_n;
   endproperty
   a_address_detect_enable: assert property (p_address_detect_enable) else $error("irq on data in address mode");
   property p_idle;
      @(posedge pclk) disable iff (!presetn) done_r |-> rx_idle_flag;
   endproperty
   a_idle: assert property (p_idle) else $error("idle low after stop");
   property p_framing_error_flag;
      @(posedge pclk) disable iff (!presetn) done_r |-> wait_high_r == done_framing_error_flag_r;
   endproperty
   a_framing_error_flag: assert property (p_framing_error_flag) else $error("no wait after bad stop");
   property p_noclr;
      @(posedge pclk) disable iff (!presetn)
         overrun_flag_r && !clr_seq |=> overrun_flag_r;
   endproperty
   a_noclr: assert property (p_noclr) else $error("overrun cleared without sequence");
   // frame end: the stop sample gives a done strobe that loads or overruns
   sequence s_stop_seen;
      rx_enable && state_r == urx_pkg::ST_STOP && at_mid;
   endsequence
   sequence s_word_taken;
      done_r && (push || ovr_evt);
   endsequence
   property p_frame_end;
      @(posedge pclk) disable iff (!presetn) s_stop_seen |=> s_word_taken;
   endproperty
   a_frame_end: assert property (p_frame_end) else $error("stop sample not loaded");
   // a start seen in idle drops the idle flag on the next cycle
   sequence s_start_seen;
      rx_enable && state_r == urx_pkg::ST_IDLE && tick && !wait_high_r && !vote;
   endsequence
   property p_idle_drop;
      @(posedge pclk) disable iff (!presetn) s_start_seen |=> !rx_idle_flag;
   endproperty
   a_idle_drop: assert property (p_idle_drop) else $error("idle high in frame");
   // while a break is waited out no start may be taken
   property p_break_hold;
      @(posedge pclk) disable iff (!presetn)
         wait_high_r && state_r == urx_pkg::ST_IDLE |=> state_r == urx_pkg::ST_IDLE;
   endproperty
   a_break_hold: assert property (p_break_hold) else $error("break taken as start");
   // each data sample enters at the top, so the first bit ends lowest
   property p_lsb_first;
      @(posedge pclk) disable iff (!presetn)
         rx_enable && state_r == urx_pkg::ST_DATA && at_mid
         |=> rx_shift_register_r[8] == $past(vote);
   endproperty
   a_lsb_first: assert property (p_lsb_first) else $error("bit not shifted in");
   // with parity off no word is marked with a parity error
   property p_parity_error_flag_off;
      @(posedge pclk) disable iff (!presetn)
         s_stop_seen ##0 !parity_enable |=> !done_parity_error_flag_r;
   endproperty
   a_parity_error_flag_off: assert property (p_parity_error_flag_off) else $error("parity error with parity off");
   // a noisy word raises the noise flag with its load
   property p_noise;
      @(posedge pclk) disable iff (!presetn) push && done_noise_r |=> noise_flag_r;
   endproperty
   a_noise: assert property (p_noise) else $error("noise flag not set");
   // a wake edge with the receive interrupt enabled gives both the wake pulse and the interrupt pulse
   property p_wake;
      @(posedge pclk) disable iff (!presetn)
         wake_evt && rx_interrupt_enable |=> wake_req && !uart_irq_n;
   endproperty
   a_wake: assert property (p_wake) else $error("wake without pulses");
   // every interrupt pulse needs the shared receive interrupt enable
   property p_irq_mask;
      @(posedge pclk) disable iff (!presetn) !uart_irq_n |-> $past(rx_interrupt_enable);
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
endmodule

// >>> dv/urx_tx_model.sv
// serial transmitter model that drives the receive line of the uart receiver
`timescale 1ns/1ns
module urx_tx_model #(
   parameter int BIT_CYC = 16
) (
   input wire logic pclk,
   output logic rx_pin
);
   // ----------------------------------------
   // line driving
   // ----------------------------------------
   // idle level is high, as on a pulled-up serial line
   initial rx_pin = 1'b1;

   // bits go out lsb first, one bit time each; the line stays at the last bit
   // so that a break can be stretched without a stray high cycle
   task automatic send(input logic [11:0] bits, input int n, input int glitch);
      for (int i = 0; i < n; i++) begin
         for (int c = 0; c < BIT_CYC; c++) begin
            @(posedge pclk);
            rx_pin <= (i == glitch && c == 7) ? ~bits[i] : bits[i];
         end
      end
   endtask

   // hold one level for a number of cycles, for breaks and idle gaps
   task automatic hold(input logic lvl, input int cyc);
      @(posedge pclk);
      rx_pin <= lvl;
      repeat (cyc) @(posedge pclk);
   endtask
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the uart receiver
`timescale 1ns/1ns
`include "urx_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
$display("wrong value at %0t got %h exp %h", $time, g, e); end end
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, sleep_mode, last_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, rx_pin, rx_owned, wake_req, uart_irq_n;
   int err_count = 0;
   int checks = 0;
   int irq_cnt = 0;
   int wake_cnt = 0;
   int brk_irq = 0;
   localparam logic [11:0] a_st = `URX_OFF_STATUS;
   localparam logic [11:0] a_dat = `URX_OFF_DATA;
   localparam logic [11:0] a_ct = `URX_OFF_CTRL;
   localparam logic [11:0] a_bd = `URX_OFF_BAUD;

   urx_receiver DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_pin(rx_pin), .sleep_mode(sleep_mode), .rx_owned(rx_owned),
      .wake_req(wake_req), .uart_irq_n(uart_irq_n));
   urx_tx_model #(.BIT_CYC(16)) tx (.pclk(pclk), .rx_pin(rx_pin));

   // ----------------------------------------
   // clock, event counters, watchdog
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // irq and wake are one-cycle pulses, so counting them catches doubles
   always @(posedge pclk) begin
      if (uart_irq_n === 1'b0) irq_cnt <= irq_cnt + 1;
      if (wake_req === 1'b1) wake_cnt <= wake_cnt + 1;
   end
   initial begin
      repeat (100000) @(posedge pclk);
      err_count++;
      test_done();
   end

   // ----------------------------------------
   // bus and frame tasks
   // ----------------------------------------
   task automatic test_done();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // apb transfer held until pready is seen high; one idle cycle after release
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (n == 50) begin
         err_count++;
         test_done();
      end
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rd, {24'h00_0000, e})
   endtask
   // send a frame, then check status and the number of irq pulses it caused
   task automatic rx(input logic [11:0] b, input int n, input int g, input logic [7:0] st,
         input int ni);
      int i0;
      i0 = irq_cnt;
      tx.send(b, n, g);
      tx.hold(1'b1, 4);
      rd_chk(a_st, st);
      `CHK(irq_cnt - i0, ni)
   endtask
   function automatic logic [11:0] fr8(input logic [7:0] d);
      return {3'b001, d, 1'b0};
   endfunction

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, sleep_mode} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(a_st, 8'h20);
      rd_chk(a_ct, 8'h00);
      apb(1'b0, 12'h010, 32'h0000_0000);
      `CHK(last_err, 1'b1)
      apb(1'b1, a_bd, 32'h0000_0000);
      apb(1'b1, a_ct, 32'h0000_0021);
      `CHK(rx_owned, 1'b1)
      // idle flag must drop while a frame is in flight
      fork
         tx.send(fr8(8'hA5), 10, -1);
         begin
            repeat (40) @(posedge pclk);
            rd_chk(a_st, 8'h00);
         end
      join
      tx.hold(1'b1, 4);
      rd_chk(a_st, 8'h21);
      apb(1'b1, a_st, 32'h0000_0000);
      rd_chk(a_st, 8'h21);
      rd_chk(a_dat, 8'hA5);
      rd_chk(a_st, 8'h20);
      rx(fr8(8'h11), 10, -1, 8'h21, 1);
      rx(fr8(8'h22), 10, -1, 8'h21, 1);
      rx(fr8(8'h33), 10, -1, 8'h23, 1);
      rd_chk(a_dat, 8'h11);
      rd_chk(a_st, 8'h21);
      rd_chk(a_dat, 8'h22);
      rx(fr8(8'h5A), 10, 3, 8'h25, 1);
      rd_chk(a_dat, 8'h5A);
      // long break: zero frame, low stop, then more than 13 bit times low;
      // its interrupt falls inside the break, before the closing high bit
      brk_irq = irq_cnt;
      tx.send(12'h000, 10, -1);
      tx.hold(1'b0, 16 * 14);
      rx(12'hFFF, 1, -1, 8'h29, 0);
      `CHK(irq_cnt - brk_irq, 1)
      rd_chk(a_dat, 8'h00);
      rd_chk(a_st, 8'h20);
      apb(1'b1, a_ct, 32'h0000_0025);
      rx(fr8(8'hC1), 10, -1, 8'h31, 1);
      rx(fr8(8'h41), 10, -1, 8'h31, 1);
      apb(1'b0, a_dat, 32'h0000_0000);
      rd_chk(a_st, 8'h21);
      apb(1'b0, a_dat, 32'h0000_0000);
      apb(1'b1, a_ct, 32'h0000_002D);
      rx(fr8(8'hC1), 10, -1, 8'h21, 1);
      apb(1'b0, a_dat, 32'h0000_0000);
      apb(1'b1, a_ct, 32'h0000_0023);
      rx({2'b01, 9'h1A5, 1'b0}, 11, -1, 8'h61, 1);
      rd_chk(a_dat, 8'hA5);
      apb(1'b1, a_ct, 32'h0000_0061);
      rx(fr8(8'h05), 10, -1, 8'h21, 0);
      apb(1'b0, a_dat, 32'h0000_0000);
      rx(fr8(8'h85), 10, -1, 8'h21, 1);
      apb(1'b0, a_dat, 32'h0000_0000);
      apb(1'b1, a_ct, 32'h0000_0001);
      rx(fr8(8'h3C), 10, -1, 8'h21, 0);
      apb(1'b0, a_dat, 32'h0000_0000);
      apb(1'b1, a_ct, 32'h0000_00A1);
      sleep_mode <= 1'b1;
      // every falling edge wakes, so the word has only the start-bit fall
      rx(fr8(8'hF0), 10, -1, 8'h21, 2);
      `CHK(wake_cnt, 1)
      sleep_mode <= 1'b0;
      rd_chk(a_dat, 8'hF0);
      // reset in mid-run with a word waiting: fifo, flags and control clear
      rx(fr8(8'h77), 10, -1, 8'h21, 1);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(a_st, 8'h20);
      rd_chk(a_ct, 8'h00);
      `CHK(rx_owned, 1'b0)
      test_done();
   end
endmodule
